// file: inc/pmc_pkg.sv
// Constants, types and helpers for the port mode control block
// Function
// - Loop-back bit 14 loops data, isolates line
// - Vendor bit 9 enables 100M remote loop-back
// - 100M internal: transmit NRZI into receive
// - 100M remote: recovered data back to line
// - 10M loop: Manchester output into receive PLL
// - Full duplex: no collision, carrier on receive
// - Half duplex: collision on overlap, carrier both
// - Bit 12 enables auto-negotiation
// - Burst carries 16 advertisement bits
// - Resolve 100FD, 100HD, 10FD, 10HD order
// - Negotiate after reset only when enabled
// - Negotiation off: speed, duplex from control
// - Power-down isolates line, LEDs and MII
// - Power-down ends on clear or reset
// - Bit 15 resets all, then self-clears
// - Straps sampled at reset set defaults
// - Status bit 6 reports preamble suppression
// - Accesses without preamble are accepted
// - Local fault bit 13 until negotiation done
// - Partner remote fault sets status bit
// - Restart bit 8 restarts, self-clears
package pmc_pkg;
  localparam int ADDR_W = 8;                    // Byte address width
  localparam int CYC_W  = 12;                   // Slot timer width
  // Register indices and byte addresses
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_STAT = 8'h01;
  localparam logic [7:0] IDX_ADV  = 8'h04;
  localparam logic [7:0] IDX_LPA  = 8'h05;
  localparam logic [7:0] IDX_ANST = 8'h12;
  localparam logic [7:0] IDX_VCFG = 8'h13;
  localparam logic [7:0] ADR_CTRL = IDX_CTRL << 2;
  localparam logic [7:0] ADR_STAT = IDX_STAT << 2;
  localparam logic [7:0] ADR_ADV  = IDX_ADV << 2;
  localparam logic [7:0] ADR_LPA  = IDX_LPA << 2;
  localparam logic [7:0] ADR_ANST = IDX_ANST << 2;
  localparam logic [7:0] ADR_VCFG = IDX_VCFG << 2;
  // Field positions
  localparam int CB_RESET = 15, CB_LOOP = 14, CB_SPEED = 13;
  localparam int CB_AN_EN = 12, CB_PDOWN = 11, CB_DUPLEX = 8;
  localparam int VB_REM_LB = 9;
  localparam int AB_RESTART = 8, AB_DONE = 7;
  localparam int SB_PRE_SUP = 6, SB_AN_DONE = 5, SB_RFAULT = 4;
  localparam int SB_AN_ABLE = 3, SB_LINK = 2;
  localparam int CW_RFAULT = 13, CW_100FD = 8, CW_100HD = 7;
  localparam int CW_10FD = 6, CW_10HD = 5;
  // Values after reset and fixed fields
  localparam logic [15:0] CTRL_WMASK = 16'hf900;
  localparam logic [15:0] ADV_RST    = 16'h01e1;
  localparam logic [15:0] VCFG_RST   = 16'h0080;
  localparam logic [15:0] STAT_ABIL  = 16'h7800;
  // Timing, in ns, and derived cycle counts
  localparam int CLK_NS       = 20;
  localparam int FLP_SLOT_NS  = 62500;
  localparam int FLP_PW_NS    = 100;
  localparam int BURST_NS     = 16000000;
  localparam int FLP_SLOT_CYC = FLP_SLOT_NS / CLK_NS;
  localparam int FLP_PW_CYC   = FLP_PW_NS / CLK_NS;
  localparam int BURST_CYC    = BURST_NS / CLK_NS;
  localparam int FLP_PULSES   = 33;             // 17 clock plus 16 data
  localparam int STRAP_WAIT   = 3;              // Sync depth plus one
  typedef enum logic [1:0] {
    PMC_AN_OFF   = 2'b00,
    PMC_AN_BURST = 2'b01,
    PMC_AN_DONE  = 2'b11
  } pmc_an_state_t;
  // Highest common ability: {found, speed100, full}
  function automatic logic [2:0] pmc_resolve(input logic [15:0] c);
    if (c[CW_100FD]) return 3'b111;
    else if (c[CW_100HD]) return 3'b110;
    else if (c[CW_10FD]) return 3'b101;
    else if (c[CW_10HD]) return 3'b100;
    else return 3'b000;
  endfunction
endpackage

// file: hw/pmc_port_mode.sv
// Port mode control: loop-back, duplex, negotiation, power, reset
`timescale 1ns/100ps
module pmc_port_mode #(
  parameter int BURST_CYC = pmc_pkg::BURST_CYC  // Burst period in cycles
) (
  input  wire logic                        clk,        // 50 MHz clock
  input  wire logic                        rst_b,      // Async reset
  input  wire logic                        hsel,       // Slave select
  input  wire logic [pmc_pkg::ADDR_W-1:0]  haddr,      // Byte address
  input  wire logic [1:0]                  htrans,     // Transfer type
  input  wire logic                        hwrite,     // Write flag
  input  wire logic [2:0]                  hsize,      // Word only
  input  wire logic [31:0]                 hwdata,     // Write data
  input  wire logic                        hready,     // Bus ready
  output logic                             hreadyout,  // Slave ready
  output logic                             hresp,      // Always OKAY
  output logic [31:0]                      hrdata,     // Read data
  input  wire logic                        mii_tx_en,  // MAC transmit
  input  wire logic                        line_rx_act, // Line receive
  input  wire logic                        link_ok,    // Link monitor
  input  wire logic                        strap_an_en, // Strap pin
  input  wire logic                        strap_speed, // Strap pin
  input  wire logic                        strap_duplex, // Strap pin
  input  wire logic                        local_fault, // Fault pulse
  input  wire logic [15:0]                 lp_word,    // Partner word
  input  wire logic                        lp_word_valid, // Word strobe
  input  wire logic                        tx_nrzi_bit, // NRZI output
  input  wire logic                        rx_cdr_bit, // Recovered bit
  input  wire logic                        tx_manch_bit, // Manchester
  input  wire logic                        line_rx_bit, // Line bit
  output logic                             rx_nrzi_in, // NRZI decoder in
  output logic                             tx_mlt3_in, // MLT3 encoder in
  output logic                             rx_pll_in,  // 10M PLL in
  output logic                             line_transmit_pair_data, // Tx
  output logic                             line_transmit_pair_oe, // Tx en
  output logic                             led_oe,     // LED enable
  output logic                             mii_oe,     // MII enable
  output logic                             mii_crs,    // Carrier sense
  output logic                             mii_col,    // Collision
  output logic                             speed_100,  // Active speed
  output logic                             full_duplex // Active duplex
);
  import pmc_pkg::*;

  localparam int BURST_SLOTS = BURST_CYC / FLP_SLOT_CYC;
  localparam int SLOT_W      = $clog2(BURST_SLOTS + 1);

  // Burst must hold every pulse plus a gap
  if (BURST_SLOTS < FLP_PULSES + 1) begin : g_chk
    $error("BURST_CYC too short for one burst");
  end

  logic [5:0]       s1_q;                 // First sync stage
  logic [5:0]       s2_q;                 // Second sync stage
  logic [1:0]       init_q;               // Strap wait counter
  logic [2:0]       strap_q;              // Caught straps
  logic             strap_load;           // Load defaults once
  logic [15:0]      main_control_reg_q;   // Control register
  logic [15:0]      advertisement_reg_q;  // Advertised abilities
  logic [15:0]      vendor_config_reg_q;  // Vendor configuration
  logic [15:0]      lpa_q;                // Partner code word
  logic [15:0]      ctrl_dflt;            // Strap-based defaults
  logic             soft_rst;             // Software reset pulse
  logic             restart_q;            // Restart request
  logic             lfault_q;             // Local fault flag
  logic             rfault_q;             // Remote fault flag
  logic [2:0]       hcd_q;                // Resolved ability
  pmc_an_state_t    an_q;                 // Negotiation state
  pmc_an_state_t    an_d;
  logic [CYC_W-1:0] cyc_q;                // Slot timer
  logic [SLOT_W-1:0] slot_q;              // Slot index
  logic             flp_q;                // Pulse on the line
  logic [15:0]      cw_tx;                // Word sent in bursts
  logic             dp_wr_q;              // Write data phase
  logic             dp_rd_q;              // Read data phase
  logic [7:0]       dp_addr_q;            // Latched address
  logic [15:0]      rd_val;               // Read mux
  logic [31:0]      hrdata_q;             // Read data flop
  logic             acc;                  // Accepted transfer
  logic             wr_ctrl, wr_adv, wr_vcfg, wr_anst;
  logic             rd_stat;              // Status being read
  logic             tx_s, rx_s, link_s;   // Synchronised pins
  logic             an_en, loop_en, rem_lb, pdown;
  logic             lp_take;              // Partner word accepted

  // Pins from outside the clock domain pass two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
    end else begin
      s1_q <= {strap_duplex, strap_speed, strap_an_en,
               link_ok, line_rx_act, mii_tx_en};
      s2_q <= s1_q;
    end
  end
  assign tx_s   = s2_q[0];
  assign rx_s   = s2_q[1];
  assign link_s = s2_q[2];

  // Straps caught after release
  // Flops hold constants in reset, so sampling waits for the sync
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      init_q  <= 2'h0;
      strap_q <= 3'h0;
    end else if (init_q != 2'(STRAP_WAIT)) begin
      init_q <= init_q + 2'h1;
      if (init_q == 2'(STRAP_WAIT - 1)) begin
        strap_q <= s2_q[5:3];
      end
    end
  end
  assign strap_load = (init_q == 2'(STRAP_WAIT - 1));

  // Defaults from the straps, live or latched
  always_comb begin
    ctrl_dflt = 16'h0000;
    ctrl_dflt[CB_AN_EN]  = strap_load ? s2_q[3] : strap_q[0];
    ctrl_dflt[CB_SPEED]  = strap_load ? s2_q[4] : strap_q[1];
    ctrl_dflt[CB_DUPLEX] = strap_load ? s2_q[5] : strap_q[2];
  end

  // Bus: word accesses only, no wait on writes, one on reads
  // No preamble needed for any access
  assign acc       = hsel && htrans[1] && hready;
  assign hreadyout = !dp_rd_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
      dp_addr_q <= 8'h00;
    end else if (hready) begin
      dp_wr_q   <= acc && hwrite;
      dp_rd_q   <= acc && !hwrite;
      dp_addr_q <= acc ? haddr : dp_addr_q;
    end else begin
      dp_rd_q <= 1'b0;
    end
  end
  assign wr_ctrl = dp_wr_q && (dp_addr_q == ADR_CTRL);
  assign wr_adv  = dp_wr_q && (dp_addr_q == ADR_ADV);
  assign wr_vcfg = dp_wr_q && (dp_addr_q == ADR_VCFG);
  assign wr_anst = dp_wr_q && (dp_addr_q == ADR_ANST);
  assign rd_stat = dp_rd_q && (dp_addr_q == ADR_STAT);

  // Read mux; unmapped words read zero
  always_comb begin
    rd_val = 16'h0000;
    case (dp_addr_q)
      ADR_CTRL: rd_val = main_control_reg_q;
      ADR_STAT: begin
        rd_val = STAT_ABIL;
        rd_val[SB_PRE_SUP] = 1'b1;
        rd_val[SB_AN_DONE] = (an_q == PMC_AN_DONE);
        rd_val[SB_RFAULT]  = rfault_q;
        rd_val[SB_AN_ABLE] = 1'b1;
        rd_val[SB_LINK]    = link_s;
      end
      ADR_ADV:  rd_val = advertisement_reg_q;
      ADR_LPA:  rd_val = lpa_q;
      ADR_ANST: begin
        rd_val[15]         = hcd_q[1] & hcd_q[0];
        rd_val[13]         = hcd_q[1];
        rd_val[12]         = !hcd_q[1] & hcd_q[0] & hcd_q[2];
        rd_val[11]         = !hcd_q[1] & hcd_q[2];
        rd_val[AB_RESTART] = restart_q;
        rd_val[AB_DONE]    = (an_q == PMC_AN_DONE);
      end
      ADR_VCFG: rd_val = vendor_config_reg_q;
      default:  rd_val = 16'h0000;
    endcase
  end

  // Read data captured in the wait cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_q <= 32'h0000_0000;
    end else if (dp_rd_q) begin
      hrdata_q <= {16'h0000, rd_val};
    end
  end

  // Bit 15 held one cycle acts as reset
  assign soft_rst = main_control_reg_q[CB_RESET];

  // Control register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      main_control_reg_q <= 16'h0000;
    end else if (strap_load || soft_rst) begin
      main_control_reg_q <= ctrl_dflt;
    end else if (wr_ctrl) begin
      main_control_reg_q <= hwdata[15:0] & CTRL_WMASK;
    end
  end
  assign an_en   = main_control_reg_q[CB_AN_EN];
  assign loop_en = main_control_reg_q[CB_LOOP];
  assign pdown   = main_control_reg_q[CB_PDOWN];
  assign rem_lb  = vendor_config_reg_q[VB_REM_LB];

  // Advertisement and vendor registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      advertisement_reg_q <= ADV_RST;
      vendor_config_reg_q <= VCFG_RST;
    end else if (soft_rst) begin
      advertisement_reg_q <= ADV_RST;
      vendor_config_reg_q <= VCFG_RST;
    end else begin
      if (wr_adv) begin
        advertisement_reg_q <= hwdata[15:0];
      end
      if (wr_vcfg) begin
        vendor_config_reg_q <= hwdata[15:0];
      end
    end
  end

  // Restart on a one, zero ignored, clears itself
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_anst && hwdata[AB_RESTART] && !soft_rst;
    end
  end

  // Partner word taken only while bursts run
  assign lp_take = lp_word_valid && (an_q == PMC_AN_BURST) &&
                   pmc_resolve(advertisement_reg_q & lp_word) != 3'b000;

  // Negotiation state
  always_comb begin
    an_d = an_q;
    case (an_q)
      PMC_AN_OFF:   if (an_en) an_d = PMC_AN_BURST;
      PMC_AN_BURST: if (!an_en) an_d = PMC_AN_OFF;
                    else if (lp_take) an_d = PMC_AN_DONE;
      PMC_AN_DONE:  if (!an_en) an_d = PMC_AN_OFF;
      default:      an_d = PMC_AN_OFF;
    endcase
    if (restart_q && an_en) begin
      an_d = PMC_AN_BURST;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      an_q <= PMC_AN_OFF;
    end else if (soft_rst) begin
      an_q <= PMC_AN_OFF;
    end else begin
      an_q <= an_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hcd_q <= 3'h0;
      lpa_q <= 16'h0000;
    end else if (soft_rst || restart_q) begin
      hcd_q <= 3'h0;
      lpa_q <= 16'h0000;
    end else if (lp_take) begin
      hcd_q <= pmc_resolve(advertisement_reg_q & lp_word);
      lpa_q <= lp_word;
    end
  end

  // Local fault held until negotiation completes; set wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lfault_q <= 1'b0;
    end else if (local_fault) begin
      lfault_q <= 1'b1;
    end else if (soft_rst || lp_take) begin
      lfault_q <= 1'b0;
    end
  end

  // Partner fault sticky, read clears it; set wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rfault_q <= 1'b0;
    end else if (lp_take && lp_word[CW_RFAULT]) begin
      rfault_q <= 1'b1;
    end else if (rd_stat || soft_rst) begin
      rfault_q <= 1'b0;
    end
  end

  // Sent word with fault at bit 13
  always_comb begin
    cw_tx = advertisement_reg_q;
    cw_tx[CW_RFAULT] = advertisement_reg_q[CW_RFAULT] | lfault_q;
  end

  // Burst timing: slot timer and slot index
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_q  <= '0;
      slot_q <= '0;
    end else if (an_q != PMC_AN_BURST || restart_q) begin
      cyc_q  <= '0;
      slot_q <= '0;
    end else if (cyc_q == CYC_W'(FLP_SLOT_CYC - 1)) begin
      cyc_q  <= '0;
      slot_q <= (slot_q == SLOT_W'(BURST_SLOTS - 1)) ? '0 :
                slot_q + 1'b1;
    end else begin
      cyc_q <= cyc_q + 1'b1;
    end
  end

  // Even slots clock, odd slots carry bits LSB first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flp_q <= 1'b0;
    end else if (an_q != PMC_AN_BURST || restart_q) begin
      flp_q <= 1'b0;
    end else if (slot_q < SLOT_W'(FLP_PULSES) &&
                 cyc_q < CYC_W'(FLP_PW_CYC)) begin
      flp_q <= slot_q[0] ? cw_tx[4'(slot_q >> 1)] : 1'b1;
    end else begin
      flp_q <= 1'b0;
    end
  end

  // Forced mode when negotiation is off
  always_comb begin
    if (an_en) begin
      speed_100   = (an_q == PMC_AN_DONE) & hcd_q[1];
      full_duplex = (an_q == PMC_AN_DONE) & hcd_q[0];
    end else begin
      speed_100   = main_control_reg_q[CB_SPEED];
      full_duplex = main_control_reg_q[CB_DUPLEX];
    end
  end

  // Loop-back steering; registered to keep data paths clean
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_nrzi_in <= 1'b0;
      tx_mlt3_in <= 1'b0;
      rx_pll_in  <= 1'b0;
    end else begin
      rx_nrzi_in <= (loop_en && speed_100) ? tx_nrzi_bit : line_rx_bit;
      tx_mlt3_in <= (rem_lb && speed_100 && !loop_en) ? rx_cdr_bit :
                    tx_nrzi_bit;
      rx_pll_in  <= (loop_en && !speed_100) ? tx_manch_bit :
                    line_rx_bit;
    end
  end

  // Line pair and output enables
  // Loop-back keeps the line quiet so the partner sees no frames
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_transmit_pair_data <= 1'b0;
      line_transmit_pair_oe   <= 1'b0;
      led_oe                  <= 1'b0;
      mii_oe                  <= 1'b0;
    end else begin
      line_transmit_pair_data <= (an_q == PMC_AN_BURST) ? flp_q :
                                 speed_100 ? tx_mlt3_in : tx_manch_bit;
      line_transmit_pair_oe   <= !(loop_en || pdown);
      led_oe                  <= !pdown;
      mii_oe                  <= !pdown;
    end
  end

  // Carrier and collision; loop-back echoes own transmit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mii_crs <= 1'b0;
      mii_col <= 1'b0;
    end else if (full_duplex) begin
      mii_crs <= loop_en ? tx_s : rx_s;
      mii_col <= 1'b0;
    end else begin
      mii_crs <= tx_s || rx_s;
      mii_col <= tx_s && rx_s && !loop_en;
    end
  end

  // Checks
  a_loop_isolate: assert property (
    @(posedge clk) disable iff (!rst_b)
    loop_en |=> !line_transmit_pair_oe)
    else $error("line pair driven in loop-back");
  a_int_loop_path: assert property (
    @(posedge clk) disable iff (!rst_b)
    loop_en && speed_100 |=> rx_nrzi_in == $past(tx_nrzi_bit))
    else $error("internal 100M loop path wrong");
  a_rem_loop_path: assert property (
    @(posedge clk) disable iff (!rst_b)
    rem_lb && speed_100 && !loop_en |=> tx_mlt3_in == $past(rx_cdr_bit))
    else $error("remote loop path wrong");
  a_ten_loop_path: assert property (
    @(posedge clk) disable iff (!rst_b)
    loop_en && !speed_100 |=> rx_pll_in == $past(tx_manch_bit))
    else $error("10M loop path wrong");
  a_full_no_col: assert property (
    @(posedge clk) disable iff (!rst_b)
    full_duplex && tx_s && !rx_s && !loop_en |=> !mii_col && !mii_crs)
    else $error("full duplex carrier or collision wrong");
  a_half_collide: assert property (
    @(posedge clk) disable iff (!rst_b)
    !full_duplex && tx_s && rx_s && !loop_en |=> mii_col && mii_crs)
    else $error("half duplex overlap missed");
  a_pdown_isolate: assert property (
    @(posedge clk) disable iff (!rst_b)
    pdown |=> !mii_oe && !led_oe && !line_transmit_pair_oe)
    else $error("outputs driven in power-down");
  a_soft_rst_clear: assert property (
    @(posedge clk) disable iff (!rst_b)
    soft_rst |=> !soft_rst && an_q == PMC_AN_OFF && !rfault_q)
    else $error("software reset did not clear");
  a_prio_top: assert property (
    @(posedge clk) disable iff (!rst_b)
    lp_take && (advertisement_reg_q[CW_100FD] & lp_word[CW_100FD])
    |=> hcd_q == 3'b111 && an_q == PMC_AN_DONE)
    else $error("100M full duplex not chosen");
  // A pulse cut by leaving the burst phase is not a width error
  a_flp_width: assert property (
    @(posedge clk)
    disable iff (!rst_b || an_q != PMC_AN_BURST || restart_q)
    $rose(flp_q) && an_q == PMC_AN_BURST && !restart_q
    |-> flp_q[*5] ##1 !flp_q)
    else $error("link pulse width wrong");
  a_rfault_set: assert property (
    @(posedge clk) disable iff (!rst_b)
    lp_take && lp_word[CW_RFAULT] |=> rfault_q)
    else $error("remote fault not flagged");
  a_restart_burst: assert property (
    @(posedge clk) disable iff (!rst_b)
    restart_q && an_en && !soft_rst |=> an_q == PMC_AN_BURST && !restart_q)
    else $error("restart did not reopen bursts");
endmodule

// file: bench/pmc_far_end.sv
// Link partner model: offers one code word when asked
`timescale 1ns/100ps
module pmc_far_end (
  input  wire logic        clk,           // Shared clock
  input  wire logic        rst_b,         // Async reset
  input  wire logic        send,          // Send request
  input  wire logic [15:0] word,          // Word to offer
  output logic      [15:0] lp_word,       // Word seen by port
  output logic             lp_word_valid  // One-cycle strobe
);
  // Word means nothing off the strobe, so churn it there
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lp_word       <= 16'h0000;
      lp_word_valid <= 1'b0;
    end else begin
      lp_word       <= send ? word : ~lp_word;
      lp_word_valid <= send;
    end
  end
endmodule

// file: bench/phy_port_mode_control_tb_top.sv
// Bench for port mode control: bus tasks and scenarios
`timescale 1ns/100ps
module phy_port_mode_control_tb_top;
  import pmc_pkg::*;
  logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, link_ok = 0;
  logic mii_tx_en = 0, line_rx_act = 0, local_fault = 0;
  logic strap_an_en = 0, strap_speed = 1, strap_duplex = 1;
  logic tx_nrzi_bit = 0, rx_cdr_bit = 0, tx_manch_bit = 0;
  logic line_rx_bit = 0, lp_send = 0, rdy, hready;
  logic [7:0]  haddr = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 0, hrdata, rd_s;
  logic [15:0] lp_val = 0, lp_word;
  logic hreadyout, hresp, rx_nrzi_in, tx_mlt3_in, rx_pll_in;
  logic line_transmit_pair_data, line_transmit_pair_oe, led_oe;
  logic mii_oe, mii_crs, mii_col, speed_100, full_duplex, lp_word_valid;
  int n_mismatch = 0, checked = 0, cyc = 0;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  pmc_port_mode #(.BURST_CYC(106250)) DUT (
    .clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .mii_tx_en, .line_rx_act,
    .link_ok, .strap_an_en, .strap_speed, .strap_duplex, .local_fault,
    .lp_word, .lp_word_valid, .tx_nrzi_bit, .rx_cdr_bit, .tx_manch_bit,
    .line_rx_bit, .rx_nrzi_in, .tx_mlt3_in, .rx_pll_in,
    .line_transmit_pair_data, .line_transmit_pair_oe, .led_oe, .mii_oe,
    .mii_crs, .mii_col, .speed_100, .full_duplex);
  pmc_far_end FAR (.clk(clk), .rst_b(rst_b), .send(lp_send),
    .word(lp_val), .lp_word(lp_word), .lp_word_valid(lp_word_valid));
  always #10 clk = ~clk;
  // Snapshot bus outputs mid-cycle to dodge edge races
  always @(negedge clk) begin
    rdy = hreadyout;
    rd_s = hrdata;
  end
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("Compares %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Parallel bus: no preamble and no idle bits owed
  // One single transfer; waits on ready, never on a fixed count
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, {16'h0000, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd_s, {16'h0000, e});
    chk(hresp, 1'b0);
  endtask
  // Covers the pin synchronisers plus the output flop
  task automatic settle;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  // Drive both levels through the loop and watch one mux output; for k 1 also the line pair
  task automatic lb(input int k);
    logic [2:0] o;
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      // Unselected sources carry the inverse, so a wrong path shows
      tx_nrzi_bit <= v[0] ^ (k != 0);
      rx_cdr_bit <= v[0] ^ (k != 1);
      tx_manch_bit <= v[0] ^ (k != 2);
      line_rx_bit <= !v[0];
      settle();
      o = {rx_pll_in, tx_mlt3_in, rx_nrzi_in};
      chk(o[k], v[0]);
      if (k == 1) chk(line_transmit_pair_data, v[0]);
    end
  endtask
  task automatic partner(input logic [15:0] w);
    @(posedge clk);
    lp_val <= w;
    lp_send <= 1'b1;
    local_fault <= 1'b1;
    @(posedge clk);
    lp_send <= 1'b0;
    local_fault <= 1'b0;
    settle();
  endtask
  initial begin
    repeat (3) @(posedge clk); // Reset hold, scaled to the bench
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd(ADR_CTRL, 16'h2100);
    rd(ADR_STAT, 16'h7848);
    $display("test reset done");
    @(posedge clk);
    mii_tx_en <= 1'b1;
    settle();
    chk({mii_crs, mii_col}, 2'b00);
    @(posedge clk);
    line_rx_act <= 1'b1;
    settle();
    chk({mii_crs, mii_col}, 2'b10);
    wr(ADR_CTRL, 16'h2000);
    settle();
    chk({mii_crs, mii_col, speed_100, full_duplex}, 4'b1110);
    @(posedge clk);
    line_rx_act <= 1'b0;
    settle();
    chk({mii_crs, mii_col}, 2'b10);
    @(posedge clk);
    mii_tx_en <= 1'b0;
    $display("test duplex done");
    wr(ADR_CTRL, 16'h6100);
    settle();
    chk(line_transmit_pair_oe, 1'b0);
    lb(0);
    wr(ADR_CTRL, 16'h4100);
    lb(2);
    wr(ADR_CTRL, 16'h2100);
    wr(ADR_VCFG, 16'h0280);
    lb(1);
    $display("test loop done");
    wr(ADR_CTRL, 16'h2900);
    settle();
    chk({line_transmit_pair_oe, led_oe, mii_oe}, 3'b000);
    rd(ADR_CTRL, 16'h2900);
    wr(ADR_CTRL, 16'h8000);
    settle();
    rd(ADR_CTRL, 16'h2100);
    rd(ADR_VCFG, 16'h0080);
    chk({line_transmit_pair_oe, led_oe, mii_oe}, 3'b111);
    $display("test power done");
    link_ok <= 1'b1;
    wr(ADR_CTRL, 16'h1000);
    settle();
    chk(line_transmit_pair_data, 1'b1);
    partner(16'h2080);
    chk({speed_100, full_duplex}, 2'b10);
    rd(ADR_STAT, 16'h787c);
    rd(ADR_STAT, 16'h786c);
    rd(ADR_ANST, 16'h2080);
    wr(ADR_ANST, 16'h0100);
    partner(16'h0040);
    chk({speed_100, full_duplex}, 2'b01);
    rd(ADR_ANST, 16'h1880);
    wr(ADR_ANST, 16'h0100);
    partner(16'h0100);
    chk({speed_100, full_duplex}, 2'b11);
    rd(ADR_ANST, 16'ha080);
    $display("test negotiation done");
    tally_and_finish();
  end
endmodule
